//--- verilog/pcvl_defs.svh
// Behaviour
// (RULE1) Any reset cause loads the program counter with the reset vector and restores every register default.
// (RULE2) Reset cause is encoded as timeout/powerdown flags: power-on 1/0, watchdog 0/0, external pin 1/1.
// (RULE3) Software reads the two reset-cause bits as fields of the program flag register.
// (RULE4) Interrupt service saves the program counter in the stack buffer and jumps to the interrupt vector.
// (RULE5) Save copies accumulator and flags without the reset-cause bits; restore leaves those bits untouched.
// (RULE6) The accumulator/flag save buffer holds exactly one level; a second save overwrites the first.
// (RULE7) ROM data fetch address is high index register in bits 15:8 and low index register in bits 7:0.
// (RULE8) The ROM word fetch puts the low byte into the accumulator and the high byte into the result register.
// (RULE9) Program ROM words are 16 bits, giving two data bytes per table entry.
// (RULE10) The high index register never changes when the low index register wraps.
// (RULE11) Adding the accumulator to the low program counter byte replaces that byte with the sum.
// (RULE12) A carry out of that add increments the high program counter byte.
// (RULE13) A borrow from subtracting the accumulator leaves the high program counter byte unchanged.
// (RULE14) Interrupt return reloads the program counter from the saved stack entry.
`ifndef PCVL_DEFS_SVH
`define PCVL_DEFS_SVH

`define PCVL_RESET_VEC 16'h0000
`define PCVL_IRQ_VEC 16'h0008
`define PCVL_PC_ONE 16'h0001

// AXI4-Lite byte addresses
`define PCVL_A_CTRL 8'h00
`define PCVL_A_PC 8'h04
`define PCVL_A_ACC 8'h08
`define PCVL_A_FLAG 8'h0C
`define PCVL_A_INDEX 8'h10
`define PCVL_A_RES 8'h14
`define PCVL_A_ROMADDR 8'h18

// Flag register layout
`define PCVL_F_CARRY 0
`define PCVL_F_ZERO 1
`define PCVL_F_POWERDOWN 4
`define PCVL_F_TIMEOUT 5
`define PCVL_FLAG_SAVE_MASK 8'hCF
`define PCVL_FLAG_RST 8'h00

// Reset cause as seen in the timeout/powerdown field
`define PCVL_CAUSE_WDT_BITS 8'h00
`define PCVL_CAUSE_PIN_BITS 8'h30
`define PCVL_CAUSE_POR_BITS 8'h20

`define PCVL_RESP_OKAY 2'h0
`define PCVL_RESP_SLVERR 2'h2

`endif

//--- verilog/pcvl_pkg.sv
package pcvl_pkg;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_PUSH = 4'h1,
		OP_POP = 4'h2,
		OP_FETCH = 4'h3,
		OP_ADD_PCL = 4'h4,
		OP_SUB_PCL = 4'h5,
		OP_IRQ = 4'h6,
		OP_INTERRUPT_RETURN_INSTRUCTION = 4'h7,
		OP_STEP = 4'h8
	} pcvl_op_e;

	typedef enum logic [1:0] {
		CAUSE_POWERON = 2'h0,
		CAUSE_WATCHDOG = 2'h1,
		CAUSE_PIN = 2'h2
	} pcvl_cause_e;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} pcvl_word_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_DONE = 3'b100
	} pcvl_state_e;
endpackage

//--- verilog/pcvl_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcvl_defs.svh"

// Program counter, vectoring, save buffer and ROM lookup for an 8-bit core.
// Reset causes arrive as pins and pass two flops; any one asserts a reset of the state.
module pcvl_core #(
	parameter int ROM_AW = 16
)(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic por_rst_in,
	input wire logic pin_rst_n_in,
	input wire logic wdt_rst_in,
	// ROM port
	output logic [ROM_AW-1:0] rom_addr_out,
	output logic rom_req_out,
	input wire logic rom_ack_in,
	input wire pcvl_pkg::pcvl_word_s rom_data_in,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [15:0] pc_out,
	output logic busy_out
);
	// Address is built from two 8-bit index bytes, so only 16 fits
	if (ROM_AW != 16)
	begin : g_aw_check
		$error("ROM_AW must be 16");
	end

	// ----------------------------------------
	// Reset pin synchronisers
	// ----------------------------------------
	logic [2:0] rs_m_r;
	logic [2:0] rs_s_r;
	always_ff @(posedge core_clk_in)
	begin
		rs_m_r <= {wdt_rst_in, ~pin_rst_n_in, por_rst_in};
		rs_s_r <= rs_m_r;
	end
	wire por_s = rs_s_r[0];
	wire pin_s = rs_s_r[1];
	wire wdt_s = rs_s_r[2];
	wire any_rst = sys_rst_in | por_s | pin_s | wdt_s;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] pc_r;
	logic [15:0] stack_r;
	logic [7:0] acc_r;
	logic [7:0] flag_r;
	logic [7:0] acc_save_r;
	logic [7:0] flag_save_r;
	logic [7:0] idx_hi_r;
	logic [7:0] idx_lo_r;
	logic [7:0] res_r;
	logic [1:0] cause_r;
	pcvl_pkg::pcvl_state_e st_r;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
	wire [7:0] wa = aw_addr_r;
	wire wr_ctrl = wr_go & (wa == `PCVL_A_CTRL) & w_strb_r[0];
	wire wr_acc = wr_go & (wa == `PCVL_A_ACC) & w_strb_r[0];
	wire wr_flag = wr_go & (wa == `PCVL_A_FLAG) & w_strb_r[0];
	wire wr_idx = wr_go & (wa == `PCVL_A_INDEX);
	wire wr_pc = wr_go & (wa == `PCVL_A_PC);
	wire wr_hit = (wa == `PCVL_A_CTRL) | (wa == `PCVL_A_ACC) | (wa == `PCVL_A_FLAG)
		| (wa == `PCVL_A_INDEX) | (wa == `PCVL_A_PC);
	wire pcvl_pkg::pcvl_op_e op = pcvl_pkg::pcvl_op_e'(w_data_r[3:0]);
	wire op_go = wr_ctrl & (st_r == pcvl_pkg::ST_IDLE);
	wire ra_hit = (s_axi_araddr <= `PCVL_A_ROMADDR) & (s_axi_araddr[1:0] == 2'h0);

	assign s_axi_awready = ~aw_held_r;
	assign s_axi_wready = ~w_held_r;
	assign s_axi_arready = ~s_axi_rvalid;
	assign busy_out = (st_r != pcvl_pkg::ST_IDLE);
	assign pc_out = pc_r;

	// ----------------------------------------
	// Datapath helpers
	// ----------------------------------------
	wire [8:0] add_sum = {1'b0, pc_r[7:0]} + {1'b0, acc_r};
	wire [7:0] sub_dif = pc_r[7:0] - acc_r;
	wire [7:0] cause_bits = (cause_r == pcvl_pkg::CAUSE_WATCHDOG) ? `PCVL_CAUSE_WDT_BITS :
		(cause_r == pcvl_pkg::CAUSE_PIN) ? `PCVL_CAUSE_PIN_BITS : `PCVL_CAUSE_POR_BITS; // RULE2
	wire [7:0] flag_rd = (flag_r & `PCVL_FLAG_SAVE_MASK) | cause_bits; // RULE3
	wire [15:0] rom_a = {idx_hi_r, idx_lo_r}; // RULE7
	assign rom_addr_out = rom_a;
	assign rom_req_out = (st_r == pcvl_pkg::ST_FETCH);

	// ----------------------------------------
	// Write channel capture
	// ----------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PCVL_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid & ~aw_held_r)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~w_held_r)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `PCVL_RESP_OKAY : `PCVL_RESP_SLVERR;
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic [31:0] rd_mux;
	always_comb
	begin
		case (s_axi_araddr)
			`PCVL_A_CTRL: rd_mux = {29'h0, st_r};
			`PCVL_A_PC: rd_mux = {16'h0, pc_r};
			`PCVL_A_ACC: rd_mux = {24'h0, acc_r};
			`PCVL_A_FLAG: rd_mux = {24'h0, flag_rd};
			`PCVL_A_INDEX: rd_mux = {16'h0, idx_hi_r, idx_lo_r};
			`PCVL_A_RES: rd_mux = {24'h0, res_r};
			`PCVL_A_ROMADDR: rd_mux = {16'h0, rom_a};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PCVL_RESP_OKAY;
		end
		else if (s_axi_arvalid & ~s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= ra_hit ? `PCVL_RESP_OKAY : `PCVL_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// Reset cause capture
	// ----------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (por_s)
			cause_r <= pcvl_pkg::CAUSE_POWERON; // RULE2
		else if (wdt_s)
			cause_r <= pcvl_pkg::CAUSE_WATCHDOG; // RULE2
		else if (pin_s)
			cause_r <= pcvl_pkg::CAUSE_PIN; // RULE2
		else if (sys_rst_in)
			cause_r <= pcvl_pkg::CAUSE_POWERON;
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (any_rst)
		begin
			pc_r <= `PCVL_RESET_VEC; // RULE1
			stack_r <= `PCVL_RESET_VEC;
			acc_r <= 8'h00;
			flag_r <= `PCVL_FLAG_RST;
			acc_save_r <= 8'h00;
			flag_save_r <= `PCVL_FLAG_RST;
			idx_hi_r <= 8'h00;
			idx_lo_r <= 8'h00;
			res_r <= 8'h00;
			st_r <= pcvl_pkg::ST_IDLE;
		end
		else
		begin
			if (wr_acc)
				acc_r <= w_data_r[7:0];
			if (wr_flag)
				flag_r <= w_data_r[7:0] & `PCVL_FLAG_SAVE_MASK;
			if (wr_idx & w_strb_r[0])
				idx_lo_r <= w_data_r[7:0]; // RULE10
			if (wr_idx & w_strb_r[1])
				idx_hi_r <= w_data_r[15:8];
			if (wr_pc & (st_r == pcvl_pkg::ST_IDLE))
				pc_r <= w_data_r[15:0];
			unique case (st_r)
				pcvl_pkg::ST_IDLE:
				begin
					if (op_go)
					begin
						case (op)
							pcvl_pkg::OP_PUSH:
							begin
								acc_save_r <= acc_r; // RULE5 RULE6
								flag_save_r <= flag_r & `PCVL_FLAG_SAVE_MASK; // RULE5
							end
							pcvl_pkg::OP_POP:
							begin
								acc_r <= acc_save_r; // RULE5
								flag_r <= flag_save_r & `PCVL_FLAG_SAVE_MASK; // RULE5
							end
							pcvl_pkg::OP_FETCH: st_r <= pcvl_pkg::ST_FETCH;
							pcvl_pkg::OP_ADD_PCL:
							begin
								pc_r[7:0] <= add_sum[7:0]; // RULE11
								pc_r[15:8] <= pc_r[15:8] + {7'h00, add_sum[8]}; // RULE12
							end
							pcvl_pkg::OP_SUB_PCL: pc_r[7:0] <= sub_dif; // RULE13
							pcvl_pkg::OP_IRQ:
							begin
								stack_r <= pc_r; // RULE4
								pc_r <= `PCVL_IRQ_VEC; // RULE4
							end
							pcvl_pkg::OP_INTERRUPT_RETURN_INSTRUCTION: pc_r <= stack_r; // RULE14
							pcvl_pkg::OP_STEP: pc_r <= pc_r + `PCVL_PC_ONE;
							default: ;
						endcase
					end
				end
				pcvl_pkg::ST_FETCH:
				begin
					if (rom_ack_in)
					begin
						acc_r <= rom_data_in.lo; // RULE8 RULE9
						res_r <= rom_data_in.hi; // RULE8 RULE9
						st_r <= pcvl_pkg::ST_DONE;
					end
				end
				pcvl_pkg::ST_DONE: st_r <= pcvl_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_irq_cmd;
		op_go && op == pcvl_pkg::OP_IRQ;
	endsequence

	property p_reset_vec;
		@(posedge core_clk_in) any_rst |=> pc_r == `PCVL_RESET_VEC && acc_r == 8'h00;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("pc not cleared by reset"); // RULE1

	property p_cause_wdt;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(wdt_s && !por_s) |=> flag_rd[`PCVL_F_TIMEOUT] == 1'b0 && flag_rd[`PCVL_F_POWERDOWN] == 1'b0;
	endproperty
	a_cause_wdt: assert property (p_cause_wdt) else $error("watchdog cause wrong"); // RULE2

	property p_cause_pin;
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(pin_s && !por_s && !wdt_s) |=> flag_rd[5:4] == 2'b11;
	endproperty
	a_cause_pin: assert property (p_cause_pin) else $error("pin cause wrong"); // RULE2

	property p_irq;
		@(posedge core_clk_in) disable iff (any_rst)
		s_irq_cmd |=> pc_r == `PCVL_IRQ_VEC && stack_r == $past(pc_r);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt vectoring wrong"); // RULE4

	property p_interrupt_return_instruction;
		@(posedge core_clk_in) disable iff (any_rst)
		(op_go && op == pcvl_pkg::OP_INTERRUPT_RETURN_INSTRUCTION) |=> pc_r == $past(stack_r);
	endproperty
	a_interrupt_return_instruction: assert property (p_interrupt_return_instruction) else $error("return address wrong"); // RULE14

	property p_pop_keeps_cause;
		@(posedge core_clk_in) disable iff (any_rst)
		(op_go && op == pcvl_pkg::OP_POP) |=> flag_rd[5:4] == $past(flag_rd[5:4]);
	endproperty
	a_pop_keeps_cause: assert property (p_pop_keeps_cause) else $error("pop changed cause"); // RULE5

	property p_fetch;
		@(posedge core_clk_in) disable iff (any_rst)
		(st_r == pcvl_pkg::ST_FETCH && rom_ack_in) |=> acc_r == $past(rom_data_in.lo)
			&& res_r == $past(rom_data_in.hi);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch bytes misplaced"); // RULE8

	property p_add_carry;
		@(posedge core_clk_in) disable iff (any_rst)
		(op_go && op == pcvl_pkg::OP_ADD_PCL && !wr_pc) |=>
			pc_r[15:8] == $past(pc_r[15:8]) + {7'h00, $past(add_sum[8])};
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("pc high carry wrong"); // RULE12

	property p_sub_nobrw;
		@(posedge core_clk_in) disable iff (any_rst)
		(op_go && op == pcvl_pkg::OP_SUB_PCL) |=> pc_r[15:8] == $past(pc_r[15:8]);
	endproperty
	a_sub_nobrw: assert property (p_sub_nobrw) else $error("pc high moved on borrow"); // RULE13
endmodule
`default_nettype wire

//--- bench/pcvl_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
// ROM partner: answers fetches promptly or after a few cycles
module pcvl_rom_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic [15:0] addr_in,
	input wire logic slow_in,
	output logic ack_out,
	output pcvl_pkg::pcvl_word_s data_out
);
	logic [2:0] wait_r;
	// Off-ack data toggles so stale bytes never look valid
	always_ff @(posedge clk_in)
	begin
		ack_out <= 1'b0;
		data_out <= ~data_out;
		wait_r <= (req_in && !ack_out) ? wait_r + 3'h1 : 3'h0;
		if (rst_in)
			data_out <= 16'hA5A5;
		else if (req_in && !ack_out && (!slow_in || wait_r == 3'h4))
		begin
			ack_out <= 1'b1;
			data_out <= {addr_in[7:0] ^ 8'h5A, addr_in[15:8] ^ 8'hC3};
		end
	end
endmodule
`default_nettype wire

//--- bench/program_counter_vector_lookup_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcvl_defs.svh"
module program_counter_vector_lookup_tb_top;
	logic core_clk_in, sys_rst_in, por_rst_in, pin_rst_n_in, wdt_rst_in;
	logic rom_req_out, rom_ack_in, slow, busy_out;
	logic [15:0] rom_addr_out, pc_out, p, e;
	pcvl_pkg::pcvl_word_s rom_data_in;
	logic [7:0] s_axi_awaddr, s_axi_araddr, a;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] cause_exp [3] = '{`PCVL_CAUSE_WDT_BITS, `PCVL_CAUSE_PIN_BITS, `PCVL_CAUSE_POR_BITS};
	int failures, n_compared, cyc;
	integer seed;

	pcvl_core u_dut (.core_clk_in, .sys_rst_in, .por_rst_in, .pin_rst_n_in, .wdt_rst_in,
		.rom_addr_out, .rom_req_out, .rom_ack_in, .rom_data_in, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pc_out, .busy_out);
	pcvl_rom_model u_rom (.clk_in(core_clk_in), .rst_in(sys_rst_in), .req_in(rom_req_out),
		.addr_in(rom_addr_out), .slow_in(slow), .ack_out(rom_ack_in), .data_out(rom_data_in));

	task print_verdict;
		$display("compared=%0d failures=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task axw(input logic [7:0] ad, input logic [31:0] d);
		logic aw, w, b;
		@(posedge core_clk_in);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		b = 1'b0;
		while (!b)
		begin
			@(posedge core_clk_in);
			b = aw && w && s_axi_bvalid;
			if (!aw && s_axi_awready)
			begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready)
			begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		rs = s_axi_bresp;
	endtask

	task axr(input logic [7:0] ad);
		logic r;
		@(posedge core_clk_in);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		r = 1'b0;
		while (!r)
		begin
			@(posedge core_clk_in);
			r = s_axi_rvalid;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		rd = s_axi_rdata;
		rs = s_axi_rresp;
	endtask

	function logic [15:0] exp_jmp(input logic [15:0] pc, input logic [7:0] ac, input logic sub);
		logic [8:0] s;
		s = {1'b0, pc[7:0]} + {1'b0, ac};
		if (sub)
			return {pc[15:8], pc[7:0] - ac};
		return {pc[15:8] + {7'h0, s[8]}, s[7:0]};
	endfunction

	initial
	begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end

	// Hang guard
	always @(posedge core_clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			print_verdict;
		end
	end

	initial
	begin
		{por_rst_in, wdt_rst_in, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{sys_rst_in, pin_rst_n_in, s_axi_bready, s_axi_rready} = 4'hF;
		s_axi_wstrb = 4'hF;
		seed = 3227;
		repeat (4) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		axr(`PCVL_A_PC);
		chk(rd, 32'h0);
		axr(`PCVL_A_FLAG);
		chk(rd[7:0], 8'h20);
		axr(8'h1C);
		chk(rs, `PCVL_RESP_SLVERR);
		axw(8'h1C, 32'h0);
		chk(rs, `PCVL_RESP_SLVERR);
		for (int i = 0; i < 8; i++)
		begin
			p = 16'($random(seed));
			slow <= p[3];
			if (i == 0)
				p[7:0] = 8'hFF;
			e = {p[7:0] ^ 8'h5A, p[15:8] ^ 8'hC3};
			axw(`PCVL_A_INDEX, {16'h0, p});
			chk(rs, `PCVL_RESP_OKAY);
			axr(`PCVL_A_ROMADDR);
			chk(rd[15:0], p);
			axw(`PCVL_A_CTRL, 32'h3);
			chk(busy_out, 1'b1);
			for (int n = 0; n < 10 && !busy_out; n++)
				@(posedge core_clk_in);
			while (busy_out)
				@(posedge core_clk_in);
			axr(`PCVL_A_ACC);
			chk(rd[7:0], e[7:0]);
			axr(`PCVL_A_RES);
			chk(rd[7:0], e[15:8]);
		end
		for (int i = 0; i < 16; i++)
		begin
			p = 16'($random(seed));
			a = 8'($random(seed));
			if (i < 2)
				{p[7:0], a} = 16'hFF01;
			axw(`PCVL_A_PC, {16'h0, p});
			axw(`PCVL_A_ACC, {24'h0, a});
			axw(`PCVL_A_CTRL, 32'h4 + i[0]);
			axr(`PCVL_A_PC);
			chk(rd[15:0], exp_jmp(p, a, i[0]));
			chk(pc_out, exp_jmp(p, a, i[0]));
		end
		axw(`PCVL_A_CTRL, 32'h6);
		axr(`PCVL_A_PC);
		chk(rd[15:0], `PCVL_IRQ_VEC);
		axw(`PCVL_A_CTRL, 32'h8);
		axw(`PCVL_A_CTRL, 32'h7);
		axr(`PCVL_A_PC);
		chk(rd[15:0], exp_jmp(p, a, i_last()));
		axw(`PCVL_A_ACC, 32'h11);
		axw(`PCVL_A_FLAG, 32'h03);
		axw(`PCVL_A_CTRL, 32'h1);
		axw(`PCVL_A_ACC, 32'h9C);
		axw(`PCVL_A_FLAG, 32'hF2);
		axw(`PCVL_A_CTRL, 32'h1);
		axw(`PCVL_A_ACC, 32'h0);
		axw(`PCVL_A_FLAG, 32'h0);
		axw(`PCVL_A_CTRL, 32'h2);
		axr(`PCVL_A_ACC);
		chk(rd[7:0], 8'h9C);
		axr(`PCVL_A_FLAG);
		chk(rd[7:0], (8'hF2 & `PCVL_FLAG_SAVE_MASK) | 8'h20);
		for (int k = 0; k < 3; k++)
		begin
			axw(`PCVL_A_PC, 32'h1234);
			axw(`PCVL_A_ACC, 32'h5A);
			wdt_rst_in <= (k == 0);
			pin_rst_n_in <= (k != 1);
			por_rst_in <= (k == 2);
			repeat (3) @(posedge core_clk_in);
			{wdt_rst_in, pin_rst_n_in, por_rst_in} <= 3'b010;
			repeat (6) @(posedge core_clk_in);
			axr(`PCVL_A_FLAG);
			chk(rd[7:0], cause_exp[k]);
			axr(`PCVL_A_PC);
			chk(rd[15:0], `PCVL_RESET_VEC);
			chk(pc_out, `PCVL_RESET_VEC);
			axr(`PCVL_A_ACC);
			chk(rd[7:0], 8'h00);
		end
		print_verdict;
	end

	// Last jump loop pass was a subtract
	function logic i_last();
		return 1'b1;
	endfunction
endmodule
`default_nettype wire
